// >>> hw/vldc_pkg.sv
// shared constants and types of the serial video link receive core
package vldc_pkg;
  localparam int FRAME_W = 28;
  localparam int PAY_W = 26;
  localparam int FR_PARITY = 27;
  localparam int FR_INVERT = 26;
  localparam int PIX_W = 12;
  localparam int NGPIO = 4;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h03;
  localparam logic [7:0] REG_GPIO = 8'h0d;
  localparam logic [7:0] REG_PERR_A = 8'h1a;
  localparam logic [7:0] REG_PERR_B = 8'h1b;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  // control register fields
  localparam int CTRL_EDGE = 0;
  localparam int CTRL_SEL = 1;
  localparam int CTRL_SEL_SRC = 2;
  localparam int CTRL_BC_EN = 3;
  localparam int CTRL_EXT_OSC = 4;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] GPIO_RST = 8'h00;
  // scrambler, skew and crc seeds
  localparam logic [14:0] SCR_SEED = 15'h7fff;
  localparam logic [7:0] STAG_SEED = 8'ha5;
  localparam logic [3:0] CRC_INIT = 4'hf;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int GPIO_SPREAD_NS = 25000;
  // four updates inside the spread window, rounded down
  localparam int BC_CYC = GPIO_SPREAD_NS / CLK_PERIOD_NS / 4;
  localparam int SYNC_W = 11;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  typedef enum logic [1:0] {VLDC_LF, VLDC_HF, VLDC_TEN} vldc_mode_e;

  typedef struct packed {
    logic [PIX_W-1:0] data;
    logic line_sync;
    logic frame_sync;
  } vldc_pix_s;

  typedef struct packed {
    logic [3:0] crc;
    logic [4:0] spare;
    logic sda;
    logic [NGPIO-1:0] gpio;
    logic [1:0] mode;
  } vldc_bc_s;
endpackage

// >>> hw/vldc_core.sv
// receive core: frame decode, camera mux, pixel output, back channel
//
// Operation
// - twelve-bit low mode: one 12-bit pixel plus syncs per frame
// - twelve-bit high mode: three pixels over two frames, 37.5-75 MHz
// - ten-bit mode: two 10-bit pixels plus syncs per frame
// - each forward frame is 28 bits, layout set by mode
// - undo dc-balance inversion and scrambling before output
// - pixel strobe rate is frame rate times 1, 1.5 or 2
// - one frame word per recovered 28-bit serial frame
// - control channel runs whenever power down is released, independent of video
// - local i2c data carried over the link both ways
// - two camera inputs, exactly one active at a time
// - active camera chosen by pin or by register
// - back channel driver on only for the selected input
// - one parity bit per frame, four crc bits on back channel
// - parity errors counted in readable registers 0x1a, 0x1b
// - error counters cleared when lock is lost
// - integrity output low on forward parity error
// - four gpios, each forwarded input or local output
// - external oscillator reference forces gpio2, gpio3 local outputs
// - forwarded gpio updates fast enough for 66 khz, 25 us spread
// - output switching staggered by random skew codes
// - mode from three-level strap, sent to serializer
// - edge select 1 launches on rising edge, 0 on falling
// - power down low tri-states outputs; high enables outputs at once, then locks
`timescale 1ns/1ps
module vldc_core
  import vldc_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic power_down_n,
  input wire logic cam_sel_pin,
  input wire logic [1:0] mode_strap,
  input wire logic lock_a_pin,
  input wire logic lock_b_pin,
  input wire logic [FRAME_W-1:0] frame_a,
  input wire logic frame_a_stb,
  input wire logic [FRAME_W-1:0] frame_b,
  input wire logic frame_b_stb,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output vldc_pix_s pix_out,
  output logic pix_clk,
  output logic out_oe,
  output logic locked,
  output logic pass,
  output logic [5:0] stagger_code,
  output logic bc_en_a,
  output logic bc_en_b,
  output vldc_bc_s bc_word,
  output logic bc_stb,
  input wire logic [NGPIO-1:0] gpio_i,
  output logic [NGPIO-1:0] gpio_o,
  output logic [NGPIO-1:0] gpio_oe,
  input wire logic i2c_sda_i,
  output logic i2c_sda_o,
  output logic i2c_sda_oe
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(FIFO_DEPTH);

  function automatic logic [3:0] crc4(input logic [11:0] d);
    logic [3:0] c;
    c = CRC_INIT;
    for (int i = 11; i >= 0; i--) begin
      c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? 4'h3 : 4'h0);
    end
    return c;
  endfunction

  // pin synchronisers, first stage read only by the second
  logic [SYNC_W-1:0] s1_r, s2_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= {mode_strap, i2c_sda_i, gpio_i, lock_b_pin, lock_a_pin,
               cam_sel_pin, power_down_n};
      s2_r <= s1_r;
    end
  end
  logic pd_n_s, sel_pin_s, lock_a_s, lock_b_s, sda_s;
  logic [NGPIO-1:0] gpio_s;
  logic [1:0] strap_s;
  assign pd_n_s = s2_r[0];
  assign sel_pin_s = s2_r[1];
  assign lock_a_s = s2_r[2];
  assign lock_b_s = s2_r[3];
  assign gpio_s = s2_r[7:4];
  assign sda_s = s2_r[8];
  assign strap_s = s2_r[10:9];

  // strap capture, once the synchroniser has filled after reset
  logic [1:0] strap_cnt_r;
  logic strap_done_r;
  vldc_mode_e mode_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      strap_cnt_r <= '0;
      strap_done_r <= 1'b0;
      mode_r <= VLDC_LF;
    end else if (!strap_done_r) begin
      if (strap_cnt_r == STRAP_WAIT) begin
        strap_done_r <= 1'b1;
        mode_r <= (strap_s == 2'h0) ? VLDC_LF :
                  (strap_s == 2'h1) ? VLDC_HF : VLDC_TEN;
      end else begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end
    end
  end

  // registers
  logic [7:0] ctrl_r, gpio_reg_r, perr_a_r, perr_b_r, rdata_r;
  logic ovf_r, pass_r, lock_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      gpio_reg_r <= GPIO_RST;
    end else if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        ctrl_r <= reg_wdata;
      end
      if (reg_addr == REG_GPIO) begin
        gpio_reg_r <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: rdata_r <= ctrl_r;
        REG_GPIO: rdata_r <= gpio_reg_r;
        REG_PERR_A: rdata_r <= perr_a_r;
        REG_PERR_B: rdata_r <= perr_b_r;
        REG_STATUS: rdata_r <= {2'h0, ovf_r, pass_r, bc_en_b,
                                mode_r, lock_r};
        default: rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end
  assign reg_rdata = rdata_r;

  // input select by pin or register
  logic cam_b, lock_q, edge_sel, ext_osc;
  assign cam_b = ctrl_r[CTRL_SEL_SRC] ? ctrl_r[CTRL_SEL] : sel_pin_s;
  assign edge_sel = ctrl_r[CTRL_EDGE];
  assign ext_osc = ctrl_r[CTRL_EXT_OSC];
  // lock only with power down released
  assign lock_q = pd_n_s & strap_done_r & (cam_b ? lock_b_s : lock_a_s);

  // one input at a time; driver follows select
  // enable bit only takes effect on the already selected input
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bc_en_a <= 1'b0;
      bc_en_b <= 1'b0;
      lock_r <= 1'b0;
    end else begin
      bc_en_a <= pd_n_s & ctrl_r[CTRL_BC_EN] & !cam_b;
      bc_en_b <= pd_n_s & ctrl_r[CTRL_BC_EN] & cam_b;
      lock_r <= lock_q;
    end
  end
  assign locked = lock_r;
  assign out_oe = pd_n_s;

  // one frame word per recovered serial frame
  logic [FRAME_W-1:0] fr;
  logic fr_stb, perr;
  assign fr = cam_b ? frame_b : frame_a;
  assign fr_stb = lock_q & (cam_b ? frame_b_stb : frame_a_stb);
  // even parity over the whole frame
  assign perr = fr_stb & (^fr);

  logic [14:0] scr_r;
  logic [PAY_W-1:0] pay;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !lock_q) begin
      scr_r <= SCR_SEED;
    end else if (fr_stb) begin
      scr_r <= {scr_r[13:0], scr_r[14] ^ scr_r[13]};
    end
  end
  assign pay = (fr[FR_INVERT] ? ~fr[PAY_W-1:0] : fr[PAY_W-1:0]) ^
               {scr_r[10:0], scr_r};

  // per-input error counters, saturating, cleared on lock loss
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !lock_q) begin
      perr_a_r <= '0;
      perr_b_r <= '0;
    end else if (perr) begin
      if (!cam_b && perr_a_r != 8'hff) begin
        perr_a_r <= perr_a_r + 8'h01;
      end
      if (cam_b && perr_b_r != 8'hff) begin
        perr_b_r <= perr_b_r + 8'h01;
      end
    end
  end

  // integrity low from an errored frame until a clean one
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pass_r <= 1'b1;
    end else if (perr) begin
      pass_r <= 1'b0;
    end else if (fr_stb) begin
      pass_r <= 1'b1;
    end
  end
  assign pass = pass_r;

  // frame layout per mode
  logic hf_ph_r;
  logic [5:0] hf_lo_r;
  logic [1:0] n_push;
  vldc_pix_s p0, p1;
  logic rx_sda, rx_sda_vld;
  always_comb begin
    n_push = 2'h0;
    p0 = '0;
    p1 = '0;
    rx_sda = 1'b1;
    rx_sda_vld = 1'b0;
    case (mode_r)
      VLDC_LF: begin
        n_push = 2'h1;
        p0 = {pay[11:0], pay[12], pay[13]};
        rx_sda = pay[14];
        rx_sda_vld = pay[15];
      end
      // half of the third pixel rides in each frame
      VLDC_HF: begin
        n_push = hf_ph_r ? 2'h2 : 2'h1;
        p0 = {pay[11:0], pay[12], pay[13]};
        p1 = {pay[19:14], hf_lo_r, pay[12], pay[13]};
        rx_sda = pay[20];
        rx_sda_vld = pay[21];
      end
      // two ten-bit pixels sharing one pair of syncs
      VLDC_TEN: begin
        n_push = 2'h2;
        p0 = {2'h0, pay[9:0], pay[20], pay[21]};
        p1 = {2'h0, pay[19:10], pay[20], pay[21]};
        rx_sda = pay[22];
        rx_sda_vld = pay[23];
      end
      default: begin
        n_push = 2'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !lock_q) begin
      hf_ph_r <= 1'b0;
      hf_lo_r <= '0;
    end else if (fr_stb && mode_r == VLDC_HF) begin
      hf_ph_r <= !hf_ph_r;
      if (!hf_ph_r) begin
        hf_lo_r <= pay[19:14];
      end
    end
  end

  // pixel clock, continuous while locked
  logic pix_clk_r, launch, pop, push_ok;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !lock_q) begin
      pix_clk_r <= 1'b0;
    end else begin
      pix_clk_r <= !pix_clk_r;
    end
  end
  assign pix_clk = pix_clk_r;
  // launch on the edge being formed this cycle
  assign launch = lock_q & (edge_sel ? !pix_clk_r : pix_clk_r);

  // pixel queue turns frame rate into pixel rate
  vldc_pix_s pend [FIFO_DEPTH];
  logic [PW-1:0] wp_r, rp_r;
  logic [PW:0] cnt_r;
  assign pop = launch && cnt_r != '0;
  // a frame whose pixels will not fit is dropped whole
  assign push_ok = fr_stb &&
                   (cnt_r - (PW+1)'(pop) + (PW+1)'(n_push) <= DEPTH_C);
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !lock_q) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push_ok) begin
        wp_r <= wp_r + PW'(n_push);
      end
      if (pop) begin
        rp_r <= rp_r + PW'(1);
      end
      cnt_r <= cnt_r + (push_ok ? (PW+1)'(n_push) : '0) - (PW+1)'(pop);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (push_ok) begin
      pend[wp_r] <= p0;
      if (n_push == 2'h2) begin
        pend[wp_r + PW'(1)] <= p1;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ovf_r <= 1'b0;
    end else if (fr_stb && !push_ok) begin
      ovf_r <= 1'b1;
    end else if (reg_rd && reg_addr == REG_STATUS) begin
      ovf_r <= 1'b0;
    end
  end

  // data and syncs leave as one word
  vldc_pix_s pix_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pix_r <= '0;
    end else if (pop) begin
      pix_r <= pend[rp_r];
    end
  end
  assign pix_out = pix_r;

  // random skew codes for three output banks, fresh each launch that pops a pixel
  logic [7:0] stag_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stag_r <= STAG_SEED;
    end else if (pop) begin
      stag_r <= {stag_r[6:0], stag_r[7] ^ stag_r[5] ^ stag_r[4] ^ stag_r[3]};
    end
  end
  assign stagger_code = stag_r[5:0];

  // gpio direction, oscillator reference forces two outputs
  logic [NGPIO-1:0] dir_eff;
  assign dir_eff = gpio_reg_r[7:4] | (ext_osc ? 4'hc : 4'h0);
  assign gpio_o = gpio_reg_r[3:0];
  assign gpio_oe = dir_eff & {NGPIO{pd_n_s}};

  // forwarded i2c data drives the local line open drain
  logic sda_hold_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !lock_q) begin
      sda_hold_r <= 1'b1;
    end else if (fr_stb && rx_sda_vld) begin
      sda_hold_r <= rx_sda;
    end
  end
  assign i2c_sda_o = 1'b0;
  assign i2c_sda_oe = pd_n_s & !sda_hold_r;

  // periodic back channel word, sent with or without video
  logic [7:0] bc_tmr_r;
  vldc_bc_s bc_nxt, bc_r;
  logic bc_stb_r;
  always_comb begin
    bc_nxt = '0;
    bc_nxt.mode = mode_r;
    bc_nxt.gpio = gpio_s & ~dir_eff;
    bc_nxt.sda = sda_s;
    bc_nxt.crc = crc4({bc_nxt.spare, bc_nxt.sda, bc_nxt.gpio, bc_nxt.mode});
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !pd_n_s || !strap_done_r) begin
      bc_tmr_r <= '0;
      bc_r <= '0;
      bc_stb_r <= 1'b0;
    end else begin
      bc_stb_r <= bc_tmr_r == '0;
      if (bc_tmr_r == '0) begin
        bc_tmr_r <= 8'(BC_CYC - 1);
        bc_r <= bc_nxt;
      end else begin
        bc_tmr_r <= bc_tmr_r - 8'h01;
      end
    end
  end
  assign bc_word = bc_r;
  assign bc_stb = bc_stb_r;

  // checks
  // integrity drop
  a_pass_on_error: assert property (@(posedge clk_sys) disable iff (!rst_n)
    perr |=> !pass) else $error("integrity stayed high on parity error");
  a_cnt_lock_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !lock_q |=> perr_a_r == 8'h00 && perr_b_r == 8'h00)
    else $error("error counter kept after lock loss");
  a_cnt_saturate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    perr_a_r == 8'hff && lock_q |=> perr_a_r == 8'hff)
    else $error("error counter wrapped");
  a_cnt_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    perr && !cam_b && lock_q && perr_a_r != 8'hff |=>
    perr_a_r == $past(perr_a_r) + 8'h01)
    else $error("error counter missed a parity error");
  a_one_input: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(bc_en_a && bc_en_b)) else $error("both back channels driven");
  a_bc_follow_sel: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ##1 bc_en_b |-> $past(cam_b) && $past(ctrl_r[CTRL_BC_EN]))
    else $error("back channel on for unselected input");
  a_launch_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pop |=> pix_clk == $past(edge_sel))
    else $error("data launched on wrong clock edge");
  a_outputs_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !pd_n_s |-> !out_oe && gpio_oe == '0 && !i2c_sda_oe ##1 !locked)
    else $error("output driven while powered down");
  a_gpio_ext_osc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ext_osc && pd_n_s |-> gpio_oe[3:2] == 2'b11 && bc_nxt.gpio[3:2] == 2'b00)
    else $error("gpio2 or gpio3 forwarded in oscillator mode");
  a_ten_two_pix: assert property (@(posedge clk_sys) disable iff (!rst_n)
    push_ok && mode_r == VLDC_TEN && lock_q ##1 lock_q |->
    cnt_r == $past(cnt_r) + 2'd2 - $past(pop))
    else $error("ten-bit frame did not yield two pixels");
  a_bc_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bc_stb && pd_n_s |=> !bc_stb [*5])
    else $error("back channel word repeated too soon");
  c_parity_error: cover property (@(posedge clk_sys) disable iff (!rst_n)
    perr ##1 fr_stb && !perr);
  c_cam_switch: cover property (@(posedge clk_sys) disable iff (!rst_n)
    bc_en_a ##[1:50] bc_en_b);
  c_hf_three: cover property (@(posedge clk_sys) disable iff (!rst_n)
    push_ok && mode_r == VLDC_HF && hf_ph_r);
  c_overflow: cover property (@(posedge clk_sys) disable iff (!rst_n)
    fr_stb && !push_ok);
endmodule // vldc_core

// >>> bench/vldc_ser_model.sv
// serializer stand-in: encodes, balances and scrambles forward frames
`timescale 1ns/1ps
module vldc_ser_model
  import vldc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic seed_n,
  input wire logic req,
  input wire logic [1:0] mode,
  input wire logic [11:0] p0,
  input wire logic [11:0] p1,
  input wire logic ls,
  input wire logic fs,
  input wire logic sda,
  input wire logic bad,
  output logic [FRAME_W-1:0] frame,
  output logic stb
);
  logic [14:0] lfsr_r;
  logic [PAY_W-1:0] raw;
  logic [PAY_W-1:0] scr;
  logic inv;
  logic [FRAME_W-1:0] word;
  initial begin
    frame = '0;
    stb = 1'b0;
  end
  always_comb begin
    if (mode == 2'h0)
      raw = {10'h000, 1'b1, sda, fs, ls, p0};
    else if (mode == 2'h1)
      raw = {4'h0, 1'b1, sda, p1[5:0], fs, ls, p0};
    else
      raw = {2'h0, 1'b1, sda, fs, ls, p1[9:0], p0[9:0]};
    scr = raw ^ {lfsr_r[10:0], lfsr_r};
  end
  // invert heavy words, then even parity; bad flips it
  always_comb begin
    inv = ($countones(scr) > 13);
    word = {1'b0, inv, scr ^ {PAY_W{inv}}};
    word[FR_PARITY] = ^word[FR_INVERT:0] ^ bad;
  end
  // one frame per request; the wire toggles when idle
  always @(posedge clk_sys) begin
    if (!seed_n)
      lfsr_r <= SCR_SEED;
    else if (req)
      lfsr_r <= {lfsr_r[13:0], lfsr_r[14] ^ lfsr_r[13]};
    stb <= req;
    frame <= req ? word : ~frame;
  end
endmodule // vldc_ser_model

// >>> bench/vldc_core_tb.sv
// self-checking bench of the link receive core
`timescale 1ns/1ps
module vldc_core_tb;
  import vldc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic power_down_n = 1'b1;
  logic cam_sel_pin = 1'b0;
  logic [1:0] mode_strap = 2'h0;
  logic lock_a_pin = 1'b1;
  logic lock_b_pin = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, rd_val;
  vldc_pix_s pix_out, last_pix;
  vldc_pix_s exp_q[$];
  vldc_bc_s bc_word;
  logic pix_clk, out_oe, locked, pass, bc_en_a, bc_en_b, bc_stb;
  logic [5:0] stagger_code, last_stag;
  logic [NGPIO-1:0] gpio_i, gpio_o, gpio_oe;
  logic [NGPIO-1:0] gpio_drv = 4'h0;
  logic i2c_sda_i, i2c_sda_o, i2c_sda_oe;
  logic sda_drv = 1'b1;
  logic [FRAME_W-1:0] ser_frame;
  logic ser_stb, to_b = 1'b0, req = 1'b0, mon_on = 1'b0;
  logic f_ls = 1'b0, f_fs = 1'b0, f_sda = 1'b1, f_bad = 1'b0;
  logic [11:0] f_p0 = 12'h000, f_p1 = 12'h000;
  logic [1:0] f_mode = 2'h0, m;
  logic hf_ph = 1'b0;
  logic [5:0] hf_lo = 6'h00;
  logic [31:0] rnd;
  int mismatches = 0, check_count = 0, cyc = 0, stag_moves = 0;

  // shared pins resolve from the core's enables; data line pulled up
  assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & gpio_drv);
  assign i2c_sda_i = sda_drv & ~(i2c_sda_oe & ~i2c_sda_o);
  always #20 clk_sys = ~clk_sys;

  vldc_core DUT (.clk_sys(clk_sys), .rst_n(rst_n),
    .power_down_n(power_down_n), .cam_sel_pin(cam_sel_pin),
    .mode_strap(mode_strap), .lock_a_pin(lock_a_pin),
    .lock_b_pin(lock_b_pin), .frame_a(ser_frame),
    .frame_a_stb(ser_stb & ~to_b), .frame_b(ser_frame),
    .frame_b_stb(ser_stb & to_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pix_out(pix_out), .pix_clk(pix_clk),
    .out_oe(out_oe), .locked(locked), .pass(pass),
    .stagger_code(stagger_code), .bc_en_a(bc_en_a), .bc_en_b(bc_en_b),
    .bc_word(bc_word), .bc_stb(bc_stb), .gpio_i(gpio_i),
    .gpio_o(gpio_o), .gpio_oe(gpio_oe), .i2c_sda_i(i2c_sda_i),
    .i2c_sda_o(i2c_sda_o), .i2c_sda_oe(i2c_sda_oe));

  vldc_ser_model ser (.clk_sys(clk_sys), .seed_n(rst_n & lock_a_pin),
    .req(req), .mode(f_mode), .p0(f_p0), .p1(f_p1), .ls(f_ls),
    .fs(f_fs), .sda(f_sda), .bad(f_bad), .frame(ser_frame),
    .stb(ser_stb));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // one frame from the serializer, expected pixels queued for the monitor
  task automatic send_frame(input logic [11:0] p0, input logic [11:0] p1,
      input logic ls, input logic fs, input logic sda, input logic bad);
    @(posedge clk_sys);
    {f_p0, f_p1, f_ls, f_fs, f_sda, f_bad} <= {p0, p1, ls, fs, sda, bad};
    req <= 1'b1;
    @(posedge clk_sys);
    req <= 1'b0;
    if (m == 2'h0)
      exp_q.push_back(vldc_pix_s'({p0, ls, fs}));
    else if (m == 2'h2) begin
      exp_q.push_back(vldc_pix_s'({2'h0, p0[9:0], ls, fs}));
      exp_q.push_back(vldc_pix_s'({2'h0, p1[9:0], ls, fs}));
    end else begin
      // high mode: third pixel is this half over the previous frame's half
      exp_q.push_back(vldc_pix_s'({p0, ls, fs}));
      if (hf_ph)
        exp_q.push_back(vldc_pix_s'({p1[5:0], hf_lo, ls, fs}));
      hf_lo = p1[5:0];
      hf_ph = !hf_ph;
    end
    repeat (6) @(posedge clk_sys);
  endtask

  function automatic logic [3:0] crc4(input logic [11:0] d);
    logic [3:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 11; i >= 0; i--) begin
      fb = c[3] ^ d[i];
      c = {c[2:0], 1'b0} ^ {2'h0, fb, fb};
    end
    return c;
  endfunction

  task automatic wait_bc();
    int i;
    i = 0;
    do begin
      @(posedge clk_sys);
      #1 i++;
    end while (bc_stb !== 1'b1 && i < 200);
    check(bc_stb, 1'b1);
    check(bc_word.crc, crc4(bc_word[11:0]));
    check(bc_word.spare, 5'h00);
  endtask

  // pixel monitor, mux exclusion and the hang limit
  always @(posedge clk_sys) begin
    #1;
    if (mon_on && pix_out !== last_pix) begin
      last_pix = pix_out;
      if (exp_q.size() == 0)
        check(pix_out, 32'hffff_ffff);
      else
        check(pix_out, exp_q.pop_front());
    end
    if (mon_on && stagger_code !== last_stag)
      stag_moves++;
    last_stag = stagger_code;
    if (bc_en_a === 1'b1 && bc_en_b === 1'b1)
      check(2'h3, 2'h1);
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    void'($urandom(767));
    for (int k = 0; k < 3; k++) begin
      m = 2'(k);
      mon_on = 1'b0;
      hf_ph = 1'b0;
      @(posedge clk_sys);
      rst_n <= 1'b0;
      mode_strap <= m;
      f_mode <= m;
      lock_a_pin <= 1'b1;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      reg_read(REG_CTRL, rd_val);
      check(rd_val, CTRL_RST);
      reg_read(REG_GPIO, rd_val);
      check(rd_val, GPIO_RST);
      reg_read(8'h7e, rd_val);
      check(rd_val, 8'h00);
      for (int i = 0; i < 40 && locked !== 1'b1; i++)
        @(posedge clk_sys);
      check(locked, 1'b1);
      reg_read(REG_STATUS, rd_val);
      check(rd_val & 8'h07, {m, 1'b1});
      wait_bc();
      check(bc_word.mode, m);
      last_pix = pix_out;
      mon_on = 1'b1;
      for (int i = 0; i < 24; i++) begin
        rnd = $urandom;
        // in ten-bit mode syncs move only every eight frames
        if (m == 2'h2)
          send_frame({rnd[11:1], 1'b0}, {rnd[23:13], 1'b1}, i[3], i[3],
            1'b1, 1'b0);
        else
          send_frame({rnd[11:2], 1'b0, i[0]}, {rnd[23:14], 2'h2}, rnd[12],
            rnd[13], 1'b1, 1'b0);
      end
      check(exp_q.size(), 0);
      check(stag_moves > 0, 1'b1);
      if (m == 2'h0) begin
        send_frame(12'h0a0, 12'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        check(i2c_sda_oe, 1'b1);
        send_frame(12'h0a1, 12'h0, 1'b0, 1'b0, 1'b1, 1'b0);
        check(i2c_sda_oe, 1'b0);
        for (int j = 0; j < 260; j++)
          send_frame(12'(j), 12'h0, 1'b0, 1'b0, 1'b1, 1'b1);
        check(pass, 1'b0);
        reg_write(REG_PERR_A, 8'h00);
        reg_read(REG_PERR_A, rd_val);
        check(rd_val, 8'hff);
        send_frame(12'h555, 12'h0, 1'b1, 1'b0, 1'b1, 1'b0);
        check(pass, 1'b1);
        mon_on = 1'b0;
        lock_a_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        check(locked, 1'b0);
        reg_read(REG_PERR_A, rd_val);
        check(rd_val, 8'h00);
      end
      mon_on = 1'b0;
      exp_q.delete();
      $display("test stream mode %0d done", m);
    end
    // select B by register first, then enable its driver
    reg_write(REG_CTRL, 8'h06);
    reg_write(REG_CTRL, 8'h0e);
    repeat (4) @(posedge clk_sys);
    check({bc_en_a, bc_en_b}, 2'b01);
    to_b <= 1'b1;
    send_frame(12'h123, 12'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    reg_read(REG_PERR_B, rd_val);
    check(rd_val, 8'h01);
    to_b <= 1'b0;
    reg_write(REG_CTRL, 8'h09);
    for (int s = 0; s < 2; s++) begin
      cam_sel_pin <= s[0];
      repeat (6) @(posedge clk_sys);
      check({bc_en_a, bc_en_b}, s ? 2'b01 : 2'b10);
    end
    $display("test camera select done");
    reg_write(REG_GPIO, 8'h35);
    gpio_drv <= 4'($urandom);
    sda_drv <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check({gpio_oe, gpio_o}, 8'h35);
    wait_bc();
    check(bc_word.gpio, {gpio_drv[3:2], 2'b00});
    check(bc_word.sda, 1'b0);
    reg_write(REG_CTRL, 8'h19);
    repeat (4) @(posedge clk_sys);
    check(gpio_oe, 4'hf);
    $display("test gpio done");
    power_down_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check({out_oe, locked, pix_clk}, 3'b000);
    $display("test power down done");
    wrap_up();
  end
endmodule // vldc_core_tb
